// [design/port_pattern_pkg.sv]
// Constants, register map and state types for the port pattern interrupt block.
// Assumes a 32-bit APB slave clocked by pclk at 40 MHz.
package port_pattern_pkg;

   localparam int NUM_UNITS  = 2;
   localparam int NUM_PORTS  = 3;
   localparam int PORT_W     = 16;
   localparam int ADDR_W     = 8;
   localparam int DATA_W     = 32;
   localparam int SEL_W      = 4;
   localparam int NUM_TC     = 6;
   localparam int NUM_PCLK   = 4;

   // Arbitrary value, identifies the block type to software
   localparam logic [15:0] BLOCK_ID_VALUE = 16'h00A5;

   // Word index inside one unit window
   localparam logic [3:0] IDX_ID       = 4'h0;
   localparam logic [3:0] IDX_MODE     = 4'h1;
   localparam logic [3:0] IDX_CLK      = 4'h2;
   localparam logic [3:0] IDX_MASK0    = 4'h3;
   localparam logic [3:0] IDX_CMP0     = 4'h6;
   localparam logic [3:0] IDX_CAPT0    = 4'h9;
   localparam logic [3:0] IDX_LAST     = 4'hB;

   // Byte addresses of the unit windows and of the interrupt registers
   localparam logic [7:0] UNIT0_BASE   = 8'h00;
   localparam logic [7:0] UNIT1_BASE   = 8'h40;
   localparam logic [7:0] IRQ_STATUS   = 8'h80;
   localparam logic [7:0] IRQ_ENABLE   = 8'h84;
   localparam logic [7:0] IRQ_CLEAR    = 8'h88;

   // Field layout
   localparam int MODE_LSB  = 0;
   localparam int MODE_W    = 2;
   localparam int CLK_LSB   = 0;

   // Source select codes
   localparam logic [3:0] SEL_REF      = 4'h0;
   localparam logic [3:0] SEL_RSVD     = 4'h1;
   localparam logic [3:0] SEL_TC0      = 4'h2;
   localparam logic [3:0] SEL_PCLK0    = 4'h8;
   localparam logic [3:0] SEL_STB1     = 4'hC;
   localparam logic [3:0] SEL_STB2     = 4'hD;
   localparam logic [3:0] SEL_STB1_N   = 4'hE;
   localparam logic [3:0] SEL_STB2_N   = 4'hF;

   localparam logic [15:0] MODE_RESET  = 16'h0000;
   localparam logic [3:0]  CLK_RESET   = 4'h0;
   localparam logic [15:0] MASK_RESET  = 16'h0000;
   localparam logic [15:0] CMP_RESET   = 16'h0000;
   localparam logic [15:0] CAPT_RESET  = 16'h0000;

   typedef enum logic [1:0] {
      MODE_OFF    = 2'd0,
      MODE_STROBE = 2'd1,
      MODE_MATCH  = 2'd2,
      MODE_EVENT  = 2'd3
   } int_mode_t;

   typedef logic [NUM_PORTS-1:0][PORT_W-1:0] port_set_t;

   typedef struct packed {
      logic [15:0] mode;
      logic [3:0]  clk_sel;
      port_set_t   mask;
      port_set_t   cmp;
      port_set_t   capt;
      logic        match_prev;
   } unit_t;

   typedef struct packed {
      unit_t [NUM_UNITS-1:0]   u;
      logic [NUM_UNITS-1:0]    status;
      logic [NUM_UNITS-1:0]    enable;
      logic [NUM_UNITS-1:0]    pulse;
      logic                    irq;
      logic [DATA_W-1:0]       prdata;
      logic                    pready;
      logic                    pslverr;
   } top_state_t;

   typedef struct packed {
      logic src_prev;
   } tick_state_t;

endpackage : port_pattern_pkg

// [design/sample_tick_select.sv]
// Picks one sampling source by its select code and turns it into a one-cycle tick.
// Assumes every source is synchronous to pclk.
`timescale 1ns/1ps
module sample_tick_select
   import port_pattern_pkg::*;
(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic [SEL_W-1:0]     clk_sel,
   input  wire logic [NUM_TC-1:0]    timer_tc,
   input  wire logic [NUM_PCLK-1:0]  prog_clk,
   input  wire logic                 first_external_strobe,
   input  wire logic                 second_external_strobe,
   output logic                      tick
);
   tick_state_t s_q;
   tick_state_t s_d;
   logic        src;

   always_comb
   begin
      src = 1'b0;
      unique case (clk_sel)
         SEL_REF, SEL_RSVD: src = 1'b0;
         SEL_STB1:          src = first_external_strobe;
         SEL_STB2:          src = second_external_strobe;
         SEL_STB1_N:        src = ~first_external_strobe;
         SEL_STB2_N:        src = ~second_external_strobe;
         default:
         begin
            if (clk_sel >= SEL_PCLK0)
               src = prog_clk[2'(clk_sel - SEL_PCLK0)];
            else
               src = timer_tc[3'(clk_sel - SEL_TC0)];
         end
      endcase
      s_d.src_prev = src;
      // Reference code samples on every cycle; reserved code never; others on the rising edge
      if (clk_sel == SEL_REF)
         tick = 1'b1;
      else
         tick = src & ~s_q.src_prev;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end
endmodule : sample_tick_select

// [design/port_pattern_interrupt.sv]
// Two pattern interrupt units over 48 I/O bits, with an APB register slave.
// Assumes port and strobe inputs synchronous to pclk; pclk at 40 MHz.
// What this block does
// - Two independent units, each watching all 48 I/O bits, bit-selectable.
// - Every interrupt latches all port bits into capture, ignoring mask and direction.
// - Pins are tested whether driven as inputs or outputs.
// - Match mode fires once when all unmasked bits come to equal the compare value.
// - Event mode fires when any unmasked bit differs from the capture.
// - Capture reloads on every interrupt, re-arming change detection.
// - Strobe mode fires on each rising edge of the selected strobe, or each falling edge for the inverted codes.
// - Mode field: 3 event, 2 match, 1 strobe, 0 off; resets to zero.
// - Four-bit source select picks the port sampling clock.
// - In strobe mode the select picks the strobe; capture samples the pins on the strobe tick.
// - Per-port 16-bit mask; a set bit excludes that bit.
// - Per-port 16-bit compare value; bit gives the level needed to match.
// - Capture registers are read-only, reset to zero, hold last interrupt levels.
// - Read-only identification register per unit with a fixed value.
`timescale 1ns/1ps
module port_pattern_interrupt
   import port_pattern_pkg::*;
(
   input  wire logic                                 pclk,
   input  wire logic                                 presetn,
   input  wire logic                                 psel,
   input  wire logic                                 penable,
   input  wire logic                                 pwrite,
   input  wire logic [port_pattern_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [port_pattern_pkg::DATA_W-1:0]  pwdata,
   output logic [port_pattern_pkg::DATA_W-1:0]       prdata,
   output logic                                      pready,
   output logic                                      pslverr,
   input  wire logic [47:0]                          io_port_word,
   input  wire logic [port_pattern_pkg::NUM_TC-1:0]  timer_tc,
   input  wire logic [port_pattern_pkg::NUM_PCLK-1:0] prog_clk,
   input  wire logic                                 first_external_strobe,
   input  wire logic                                 second_external_strobe,
   output logic [port_pattern_pkg::NUM_UNITS-1:0]    unit_irq_pulse,
   output logic                                      irq
);
   import port_pattern_pkg::*;

   top_state_t               s_q;
   top_state_t               s_d;
   logic [NUM_UNITS-1:0]     tick;
   port_set_t                pins;

   assign pins = io_port_word;

   // True when any selected bit of a differs from b
   function automatic logic masked_diff(input port_set_t a,
                                        input port_set_t b,
                                        input port_set_t m);
      masked_diff = |((a ^ b) & ~m);
   endfunction : masked_diff

   // True when a byte address is an aligned, valid word inside the chosen unit's window
   function automatic logic unit_hit(input logic [ADDR_W-1:0] a,
                                     input logic               which);
      logic [ADDR_W-1:0] base;
      base = which ? UNIT1_BASE : UNIT0_BASE;
      unit_hit = (a[ADDR_W-1:6] == base[ADDR_W-1:6]) && (a[1:0] == 2'b00)
                 && (a[5:2] <= IDX_LAST);
   endfunction : unit_hit

   function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
      addr_mapped = unit_hit(a, 1'b0) || unit_hit(a, 1'b1) || a == IRQ_STATUS
                    || a == IRQ_ENABLE || a == IRQ_CLEAR;
   endfunction : addr_mapped

   genvar g;
   generate
      for (g = 0; g < NUM_UNITS; g++)
      begin : g_tick
         sample_tick_select u_tick (
            .pclk                   (pclk),
            .presetn                (presetn),
            .clk_sel                (s_q.u[g].clk_sel),
            .timer_tc               (timer_tc),
            .prog_clk               (prog_clk),
            .first_external_strobe  (first_external_strobe),
            .second_external_strobe (second_external_strobe),
            .tick                   (tick[g])
         );
      end
   endgenerate

   always_comb
   begin
      logic                  wr;
      logic                  rd;
      logic [3:0]            idx;
      logic [NUM_UNITS-1:0]  fire;
      logic [NUM_UNITS-1:0]  clr;
      logic                  match_now;
      logic                  strobe_sel;
      logic [DATA_W-1:0]     rdata;
      int_mode_t             mode;
      wr         = psel & penable & s_q.pready & pwrite;
      rd         = psel & ~penable & ~pwrite;
      idx        = paddr[5:2];
      fire       = '0;
      clr        = '0;
      match_now  = 1'b0;
      strobe_sel = 1'b0;
      rdata      = '0;
      mode       = MODE_OFF;
      s_d        = s_q;

      // Pattern evaluation per unit
      for (int i = 0; i < NUM_UNITS; i++)
      begin
         mode       = int_mode_t'(s_q.u[i].mode[MODE_LSB +: MODE_W]);
         // Pin levels are read straight from the pads, direction not considered
         match_now  = !masked_diff(pins, s_q.u[i].cmp, s_q.u[i].mask);
         strobe_sel = s_q.u[i].clk_sel >= SEL_STB1;
         unique case (mode)
            MODE_OFF:
               fire[i] = 1'b0;
            MODE_STROBE:
               fire[i] = strobe_sel & tick[i];
            MODE_MATCH:
               fire[i] = tick[i] & match_now & ~s_q.u[i].match_prev;
            MODE_EVENT:
               fire[i] = tick[i]
                         & masked_diff(pins, s_q.u[i].capt, s_q.u[i].mask);
         endcase
         if (mode == MODE_MATCH && tick[i])
            s_d.u[i].match_prev = match_now;
         else if (mode != MODE_MATCH)
            s_d.u[i].match_prev = 1'b0;
         if (fire[i])
            s_d.u[i].capt = pins;
      end

      // APB register writes, taken at the access edge
      if (wr)
      begin
         for (int i = 0; i < NUM_UNITS; i++)
         begin
            if (unit_hit(paddr, 1'(i)))
            begin
               if (idx == IDX_MODE)
                  s_d.u[i].mode = pwdata[15:0];
               if (idx == IDX_CLK)
                  s_d.u[i].clk_sel = pwdata[CLK_LSB +: SEL_W];
               for (int p = 0; p < NUM_PORTS; p++)
               begin
                  if (idx == IDX_MASK0 + 4'(p))
                     s_d.u[i].mask[p] = pwdata[PORT_W-1:0];
                  if (idx == IDX_CMP0 + 4'(p))
                     s_d.u[i].cmp[p] = pwdata[PORT_W-1:0];
               end
            end
         end
         if (paddr == IRQ_ENABLE)
            s_d.enable = pwdata[NUM_UNITS-1:0];
         if (paddr == IRQ_CLEAR)
            clr = pwdata[NUM_UNITS-1:0];
      end

      // Sticky status: a new interrupt wins over a clear in the same cycle
      s_d.status = (s_q.status & ~clr) | fire;
      s_d.pulse  = fire;
      s_d.irq    = |(s_d.status & s_d.enable);

      // Read data is fetched in the setup cycle and presented in the access cycle
      for (int i = 0; i < NUM_UNITS; i++)
      begin
         if (unit_hit(paddr, 1'(i)))
         begin
            if (idx == IDX_ID)
               rdata[15:0] = BLOCK_ID_VALUE;
            if (idx == IDX_MODE)
               rdata[15:0] = s_q.u[i].mode;
            if (idx == IDX_CLK)
               rdata[CLK_LSB +: SEL_W] = s_q.u[i].clk_sel;
            for (int p = 0; p < NUM_PORTS; p++)
            begin
               if (idx == IDX_MASK0 + 4'(p))
                  rdata[PORT_W-1:0] = s_q.u[i].mask[p];
               if (idx == IDX_CMP0 + 4'(p))
                  rdata[PORT_W-1:0] = s_q.u[i].cmp[p];
               if (idx == IDX_CAPT0 + 4'(p))
                  rdata[PORT_W-1:0] = s_q.u[i].capt[p];
            end
         end
      end
      if (paddr == IRQ_STATUS)
         rdata[NUM_UNITS-1:0] = s_q.status;
      if (paddr == IRQ_ENABLE)
         rdata[NUM_UNITS-1:0] = s_q.enable;

      s_d.prdata  = rd ? rdata : '0;
      s_d.pready  = psel & ~penable;
      s_d.pslverr = psel & ~penable & ~addr_mapped(paddr);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign prdata         = s_q.prdata;
   assign pready         = s_q.pready;
   assign pslverr        = s_q.pslverr;
   assign unit_irq_pulse = s_q.pulse;
   assign irq            = s_q.irq;

endmodule : port_pattern_interrupt

// [verification/port_pattern_assertions.sv]
// Port checks for the pattern interrupt block: APB timing and interrupt outputs.
// Bound to the top module; sees only its ports.
`timescale 1ns/1ps
module port_pattern_assertions
   import port_pattern_pkg::*;
(
   input wire logic                                  pclk,
   input wire logic                                  presetn,
   input wire logic                                  psel,
   input wire logic                                  penable,
   input wire logic                                  pwrite,
   input wire logic [port_pattern_pkg::DATA_W-1:0]   prdata,
   input wire logic                                  pready,
   input wire logic                                  pslverr,
   input wire logic [port_pattern_pkg::NUM_UNITS-1:0] unit_irq_pulse,
   input wire logic                                  irq
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_rdy; psel && !penable |=> pready && psel && penable; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready one cycle after setup");
   property p_one; pready |=> !pready; endproperty
   a_one: assert property (p_one) else $error("ready held past the access cycle");
   property p_req; pready |-> psel && penable && $past(psel && !penable); endproperty
   a_req: assert property (p_req) else $error("ready without a pending access");
   property p_idle; !pready |-> prdata == '0; endproperty
   a_idle: assert property (p_idle) else $error("read data outside an access cycle");
   property p_err; pslverr |-> pready && prdata == '0; endproperty
   a_err: assert property (p_err) else $error("slave error without ready or with data");
   property p_pls; |unit_irq_pulse |=> (unit_irq_pulse & $past(unit_irq_pulse)) == '0;
   endproperty
   a_pls: assert property (p_pls) else $error("interrupt pulse longer than a cycle");
   property p_up;
      $rose(irq) |-> |unit_irq_pulse || $past(pwrite && penable)
         || $past(pwrite && penable, 2);
   endproperty
   a_up: assert property (p_up) else $error("irq rose with no interrupt or write");
   property p_dn; $fell(irq) |-> $past(pwrite && penable) || $past(pwrite && penable, 2);
   endproperty
   a_dn: assert property (p_dn) else $error("irq fell without a register write");
   c_u0: cover property (unit_irq_pulse[0]);
   c_u1: cover property (unit_irq_pulse[1]);
   c_err: cover property (pslverr);
endmodule : port_pattern_assertions

bind port_pattern_interrupt port_pattern_assertions chk (.pclk, .presetn, .psel, .penable,
   .pwrite, .prdata, .pready, .pslverr, .unit_irq_pulse, .irq);

// [verification/port_pins_model.sv]
// Pin-side model: port levels, strobes, timer counts and programmable clocks.
// Driven by bench task calls; every change lands just after a rising pclk edge.
`timescale 1ns/1ps
module port_pins_model
   import port_pattern_pkg::*;
(
   input  wire logic                              pclk,
   output logic [47:0]                            io_port_word,
   output logic [port_pattern_pkg::NUM_TC-1:0]    timer_tc,
   output logic [port_pattern_pkg::NUM_PCLK-1:0]  prog_clk,
   output logic                                   first_external_strobe,
   output logic                                   second_external_strobe
);
   logic [11:0] src_q = '0;
   initial
      io_port_word = '0;
   assign timer_tc = src_q[5:0];
   assign prog_clk = src_q[9:6];
   assign first_external_strobe = src_q[10];
   assign second_external_strobe = src_q[11];
   task automatic set_pins(input logic [47:0] v);
      @(posedge pclk);
      io_port_word <= v;
   endtask : set_pins
   // One cycle high on a source: 0-5 timer counts, 6-9 clocks, 10-11 strobes
   task automatic pulse(input int i);
      @(posedge pclk);
      src_q[i] <= 1'b1;
      @(posedge pclk);
      src_q[i] <= 1'b0;
   endtask : pulse
endmodule : port_pins_model

// [verification/port_pattern_interrupt_test.sv]
// Bench for the pattern interrupt block: APB tasks and directed scenarios.
// Assumes the pin model and the bound checker; pclk at 40 MHz.
`timescale 1ns/1ps
module port_pattern_interrupt_test;
   import port_pattern_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, t_err;
   logic        first_external_strobe, second_external_strobe;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, t_rd;
   logic [1:0]  unit_irq_pulse;
   logic [47:0] io_port_word, pv;
   logic [5:0]  timer_tc;
   logic [3:0]  prog_clk;
   int          failures, compares, n0, n1;
   port_pattern_interrupt uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .io_port_word, .timer_tc, .prog_clk, .first_external_strobe,
      .second_external_strobe, .unit_irq_pulse, .irq);
   port_pins_model pins (.pclk, .io_port_word, .timer_tc, .prog_clk, .first_external_strobe,
      .second_external_strobe);
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   always @(negedge pclk)
   begin
      n0 += unit_irq_pulse[0];
      n1 += unit_irq_pulse[1];
   end
   function automatic logic [7:0] ad(input int u, input int i);
      return 8'(u * 64 + i * 4);
   endfunction : ad
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      // Ready, data and error are taken at the rising edge that ends the access
      do @(posedge pclk); while (pready !== 1'b1);
      t_rd = prdata;
      t_err = pslverr;
      {psel, penable} <= 2'b00;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0000_0000);
      chk($sformatf("reg %h", a), e, t_rd);
   endtask : rd
   task automatic drive(input logic [47:0] v, input int e0, input int e1);
      pins.set_pins(v);
      pv = v;
      cyc(4);
      chk("unit0 count", 32'(e0), 32'(n0));
      chk("unit1 count", 32'(e1), 32'(n1));
   endtask : drive
   task automatic complete_run;
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run
   initial
   begin
      repeat (20000) @(posedge pclk);
      failures++;
      complete_run();
   end
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int u = 0; u < 2; u++)
         for (int i = 0; i < 12; i++)
            rd(ad(u, i), i == 0 ? 32'(BLOCK_ID_VALUE) : 32'h0);
      for (int i = 0; i < 3; i++)
      begin
         wr(ad(0, i), 32'hFFFF_FFFF);
         rd(ad(0, i), i == 0 ? 32'(BLOCK_ID_VALUE) : (i == 1 ? 32'hFFFF : 32'hF));
         wr(ad(0, i), 32'h0);
      end
      wr(ad(0, 9), 32'hFFFF);
      rd(ad(0, 9), 32'h0);
      xfer(1'b0, ad(0, 12), 32'h0);
      chk("slave error", 32'h1, {31'h0, t_err});
      chk("refused data", 32'h0, t_rd);
      wr(IRQ_ENABLE, 32'h3);
      wr(ad(0, 3), 32'h1);
      wr(ad(0, 1), 32'h3);
      drive(48'h1, 0, 0);
      drive(48'h8421_0F0F_A5A5, 1, 0);
      for (int p = 0; p < 3; p++)
         rd(ad(0, 9 + p), 32'(pv[16 * p +: 16]));
      rd(IRQ_STATUS, 32'h1);
      chk("irq", 32'h1, {31'h0, irq});
      wr(IRQ_ENABLE, 32'h2);
      cyc(2);
      chk("masked irq", 32'h0, {31'h0, irq});
      wr(IRQ_CLEAR, 32'h1);
      rd(IRQ_STATUS, 32'h0);
      wr(IRQ_ENABLE, 32'h3);
      wr(ad(0, 1), 32'h0);
      wr(ad(1, 3), 32'hFFFF);
      wr(ad(1, 5), 32'hFFFF);
      wr(ad(1, 7), 32'h00F0);
      wr(ad(1, 1), 32'h2);
      drive(48'h0000_00F1_0000, 1, 0);
      drive(48'h1234_00F0_5678, 1, 1);
      rd(ad(1, 9), 32'h5678);
      wr(ad(0, 1), 32'h1);
      for (int c = 11; c < 16; c++)
      begin
         wr(ad(0, 2), 32'(c));
         cyc(3);
         n0 = 0;
         pins.pulse(10 + c % 2);
         pins.pulse(11 - c % 2);
         drive(pv, c > 11, 1);
      end
      wr(ad(0, 1), 32'h3);
      for (int c = 1; c < 12; c++)
      begin
         wr(ad(0, 2), 32'(c));
         cyc(3);
         n0 = 0;
         drive(pv ^ (48'h1 << (32 + c)), 0, 1);
         if (c > 1)
            pins.pulse(c - 2);
         drive(pv, c > 1, 1);
      end
      complete_run();
   end
endmodule : port_pattern_interrupt_test
